/* File: verilog/nvm_readback_pkg.sv */
// Package with constants and types shared by the read-back block and the core.
package nvm_readback_pkg;

  // ----------------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------------
  localparam int unsigned PROG_OP_EN_BIT   = 0;
  localparam int unsigned PAGE_ERASE_BIT   = 1;
  localparam int unsigned PAGE_WRITE_BIT   = 2;
  localparam int unsigned LOCK_FUSE_BIT    = 3;
  localparam int unsigned RWW_ENABLE_BIT   = 4;
  localparam int unsigned SIG_READ_BIT     = 5;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;

  // ----------------------------------------------------------------------
  // Arming window lengths in CPU cycles
  // ----------------------------------------------------------------------
  localparam logic [2:0]  LOAD_WINDOW      = 3'h3;
  localparam logic [2:0]  STORE_WINDOW     = 3'h4;

  // ----------------------------------------------------------------------
  // Pointer addresses for special reads
  // ----------------------------------------------------------------------
  localparam logic [15:0] PTR_FUSE_LOW     = 16'h0000;
  localparam logic [15:0] PTR_LOCK         = 16'h0001;
  localparam logic [15:0] PTR_FUSE_EXT     = 16'h0002;
  localparam logic [15:0] PTR_FUSE_HIGH    = 16'h0003;
  localparam logic [15:0] PTR_SIG1         = 16'h0000;
  localparam logic [15:0] PTR_CAL          = 16'h0001;
  localparam logic [15:0] PTR_SIG2         = 16'h0002;
  localparam logic [15:0] PTR_SIG3         = 16'h0004;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned WRITE_TIME_MIN_US = 3700;
  localparam int unsigned WRITE_TIME_MAX_US = 4500;
  localparam int unsigned WRITE_TIME_CYCLES =
    (WRITE_TIME_MIN_US * (CLK_HZ / 1_000_000) +
     WRITE_TIME_MAX_US * (CLK_HZ / 1_000_000)) / 2;
  localparam int unsigned PTR_STEP         = 2;

  // Read-back mode of the block.
  typedef enum logic [2:0] {
    MODE_IDLE = 3'b001,
    MODE_LOCK = 3'b010,
    MODE_SIG  = 3'b100
  } mode_t;

endpackage

/* File: verilog/nvm_readback_if.sv */
// Interface joining the CPU core end and the read-back block end.
`timescale 1ns/1ps
interface nvm_readback_if;
  logic        ctrl_wr;
  logic [7:0]  ctrl_wdata;
  logic [7:0]  ctrl_rdata;
  logic        load_req;
  logic        store_req;
  logic [15:0] pointer;
  logic [7:0]  load_data;
  logic        write_busy;
  logic        fetch_no_read_while_write_section_only;

  modport device (
    input  ctrl_wr, ctrl_wdata, load_req, store_req, pointer,
    output ctrl_rdata, load_data, write_busy, fetch_no_read_while_write_section_only
  );
  modport core (
    output ctrl_wr, ctrl_wdata, load_req, store_req, pointer,
    input  ctrl_rdata, load_data, write_busy, fetch_no_read_while_write_section_only
  );
endinterface

/* File: verilog/nvm_write_timer.sv */
// Programming time counter for erase, write and lock-bit operations.
`timescale 1ns/1ps
module nvm_write_timer
  import nvm_readback_pkg::*;
#(
  parameter int unsigned CYCLES = WRITE_TIME_CYCLES
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Control
  input  wire logic start,
  output logic      busy
);
  logic [19:0] count_q;
  logic        busy_q;
  logic        done;

  assign done = busy_q && (count_q == 20'h00001);
  assign busy = busy_q;

  // A reset does not abort a running write; only idle state is reset.
  // Busy is tested first, so an unknown busy bit at power-up falls
  // through to the reset branch instead of locking the timer up.
  always_ff @(posedge clk_sys) begin
    if (busy_q) begin
      count_q <= count_q - 20'h00001;
      if (done) begin
        busy_q <= 1'b0;
      end
    end else if (sys_rst) begin
      busy_q  <= 1'b0;
      count_q <= 20'h00000;
    end else if (start) begin
      busy_q  <= 1'b1;
      count_q <= 20'(CYCLES);
    end
  end
endmodule

/* File: verilog/nvm_readback_device.sv */
// Read-back block: arming window, special reads and write timing.
`timescale 1ns/1ps
module nvm_readback_device
  import nvm_readback_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = WRITE_TIME_CYCLES
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Core side
  nvm_readback_if.device        bus,
  // Non-volatile array contents (lock and fuse bits stored as one when programmed) and EEPROM busy flag
  input  wire logic [7:0]       lock_programmed,
  input  wire logic [7:0]       fuse_low_programmed,
  input  wire logic [7:0]       fuse_high_programmed,
  input  wire logic [7:0]       fuse_ext_programmed,
  input  wire logic [7:0]       sig_byte1,
  input  wire logic [7:0]       sig_byte2,
  input  wire logic [7:0]       sig_byte3,
  input  wire logic [7:0]       osc_cal_byte,
  input  wire logic [7:0]       program_mem_data,
  input  wire logic             eeprom_write_busy_flag,
  // Array control
  output logic                  nvm_op_start
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  mode_t       mode_q;
  mode_t       mode_d;
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic [2:0]  age_q;
  logic [2:0]  age_d;
  logic [7:0]  load_data_q;
  logic [7:0]  load_data_d;
  logic        start_q;
  logic        timer_busy;

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  wire logic ctrl_accept;
  wire logic arm_lock;
  wire logic arm_sig;
  wire logic lock_load;
  wire logic sig_load;
  wire logic prog_store;
  wire logic load_timeout;
  wire logic store_timeout;
  wire logic [7:0] lock_value;
  wire logic [7:0] sig_value;

  // Window test shared by loads, stores and timeouts; the age saturates
  // at seven, so a stale arming can never wrap back into a window.
  function automatic logic in_window(input logic [2:0] age,
                                     input logic [2:0] limit);
    in_window = (age < limit);
  endfunction

  // Programming and fuse reads are refused while the EEPROM writes.
  assign ctrl_accept = bus.ctrl_wr && !eeprom_write_busy_flag;

  // Arming codes carried by a control write.
  assign arm_lock  = bus.ctrl_wdata[LOCK_FUSE_BIT] &&
                     bus.ctrl_wdata[PROG_OP_EN_BIT];
  assign arm_sig   = bus.ctrl_wdata[SIG_READ_BIT] &&
                     bus.ctrl_wdata[PROG_OP_EN_BIT];

  // Loads and stores that fall inside their arming window.
  assign lock_load = (mode_q == MODE_LOCK) && bus.load_req &&
                     in_window(age_q, LOAD_WINDOW);
  assign sig_load  = (mode_q == MODE_SIG) && bus.load_req &&
                     in_window(age_q, LOAD_WINDOW);
  assign prog_store = ctrl_q[PROG_OP_EN_BIT] && (mode_q != MODE_SIG) &&
                      bus.store_req && in_window(age_q, STORE_WINDOW) &&
                      !timer_busy;

  // Timeouts; lock mode waits out the longer store window before it ends.
  assign load_timeout  = !in_window(age_q, LOAD_WINDOW);
  assign store_timeout = !in_window(age_q, STORE_WINDOW);

  // Stored bits are one when programmed, so invert for read-back.
  function automatic logic [7:0] fuse_read(input logic [7:0] programmed);
    fuse_read = ~programmed;
  endfunction

  // Lock/fuse selection by pointer; other pointers return all ones.
  assign lock_value =
    (bus.pointer == PTR_LOCK)      ? fuse_read(lock_programmed) :
    (bus.pointer == PTR_FUSE_LOW)  ? fuse_read(fuse_low_programmed) :
    (bus.pointer == PTR_FUSE_HIGH) ? fuse_read(fuse_high_programmed) :
    (bus.pointer == PTR_FUSE_EXT)  ? fuse_read(fuse_ext_programmed) :
    8'hff;

  // Reserved signature pointers return zero; software must avoid them.
  assign sig_value =
    (bus.pointer == PTR_SIG1) ? sig_byte1 :
    (bus.pointer == PTR_CAL)  ? osc_cal_byte :
    (bus.pointer == PTR_SIG2) ? sig_byte2 :
    (bus.pointer == PTR_SIG3) ? sig_byte3 :
    8'h00;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Mode, window age and load result; a control write in the same cycle
  // wins over any clear, so software never loses a fresh arming.
  always_comb begin
    mode_d      = mode_q;
    ctrl_d      = ctrl_q;
    age_d       = (age_q == 3'h7) ? age_q : age_q + 3'h1;
    load_data_d = load_data_q;
    if (lock_load) begin
      load_data_d = lock_value;
    end else if (sig_load) begin
      load_data_d = sig_value;
    end else if (bus.load_req) begin
      load_data_d = program_mem_data;
    end
    case (mode_q)
      MODE_LOCK: begin
        if (lock_load || prog_store || (load_timeout && store_timeout)) begin
          mode_d = MODE_IDLE;
          ctrl_d = CTRL_RESET;
        end
      end
      MODE_SIG: begin
        if (sig_load || load_timeout) begin
          mode_d = MODE_IDLE;
          ctrl_d = CTRL_RESET;
        end
      end
      default: begin
        if (ctrl_q[PROG_OP_EN_BIT] && (prog_store || store_timeout)) begin
          ctrl_d = CTRL_RESET;
        end
      end
    endcase
    if (ctrl_accept) begin
      ctrl_d = bus.ctrl_wdata;
      age_d  = 3'h0;
      mode_d = arm_sig ? MODE_SIG : (arm_lock ? MODE_LOCK : MODE_IDLE);
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // All state restarts on reset; the write timer below deliberately not.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode_q      <= MODE_IDLE;
      ctrl_q      <= CTRL_RESET;
      age_q       <= 3'h7;
      load_data_q <= 8'h00;
      start_q     <= 1'b0;
    end else begin
      mode_q      <= mode_d;
      ctrl_q      <= ctrl_d;
      age_q       <= age_d;
      load_data_q <= load_data_d;
      start_q     <= prog_store && !eeprom_write_busy_flag &&
                     (ctrl_q[PAGE_ERASE_BIT] || ctrl_q[PAGE_WRITE_BIT] ||
                      mode_q == MODE_LOCK);
    end
  end

  // ----------------------------------------------------------------------
  // Programming timer
  // ----------------------------------------------------------------------
  nvm_write_timer #(
    .CYCLES (WRITE_CYCLES)
  ) u_timer (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .start   (start_q),
    .busy    (timer_busy)
  );

  // Outputs; busy also keeps fetches in the safe section.
  assign bus.load_data       = load_data_q;
  assign bus.ctrl_rdata      = {ctrl_q[7:1], timer_busy | ctrl_q[0]};
  assign bus.write_busy      = timer_busy;
  assign bus.fetch_no_read_while_write_section_only = timer_busy;
  assign nvm_op_start        = start_q;
endmodule

/* File: verilog/nvm_readback_core.sv */
// Core end: issues control writes, loads and stores on request.
`timescale 1ns/1ps
module nvm_readback_core
  import nvm_readback_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Link to the block
  nvm_readback_if.core     bus,
  // User side
  input  wire logic        user_ctrl_wr,
  input  wire logic [7:0]  user_ctrl_data,
  input  wire logic        user_load,
  input  wire logic        user_store,
  input  wire logic        user_ptr_set,
  input  wire logic [15:0] user_ptr,
  output logic [7:0]       user_result,
  output logic             user_result_valid,
  output logic             user_busy
);
  logic [15:0] ptr_q;
  logic        ctrl_wr_q;
  logic [7:0]  ctrl_wdata_q;
  logic        load_q;
  logic        store_q;
  logic        valid_q;

  // Software waits for the block before new control writes.
  wire logic can_write;
  assign can_write = !bus.write_busy;

  // Requests go out one cycle after the user asks; stores step the pointer.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ptr_q        <= 16'h0000;
      ctrl_wr_q    <= 1'b0;
      ctrl_wdata_q <= 8'h00;
      load_q       <= 1'b0;
      store_q      <= 1'b0;
      valid_q      <= 1'b0;
    end else begin
      ctrl_wr_q    <= user_ctrl_wr && can_write;
      ctrl_wdata_q <= user_ctrl_data;
      load_q       <= user_load;
      store_q      <= user_store;
      valid_q      <= load_q;
      if (user_ptr_set) begin
        ptr_q <= user_ptr;
      end else if (store_q) begin
        ptr_q <= ptr_q + 16'(PTR_STEP);
      end
    end
  end

  assign bus.ctrl_wr        = ctrl_wr_q;
  assign bus.ctrl_wdata     = ctrl_wdata_q;
  assign bus.load_req       = load_q;
  assign bus.store_req      = store_q;
  assign bus.pointer        = ptr_q;
  assign user_result        = bus.load_data;
  assign user_result_valid  = valid_q;
  assign user_busy          = bus.write_busy | bus.fetch_no_read_while_write_section_only;
endmodule

/* File: test/nvm_readback_sva.sv */
// Checker for the link between the core end and the read-back block.
`timescale 1ns/1ps
module nvm_readback_sva
  import nvm_readback_pkg::*;
#(
  parameter int WRITE_CYCLES = 20
) (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  // Link signals
  input wire logic       load_req,
  input wire logic       store_req,
  input wire logic [7:0] ctrl_rdata,
  input wire logic [7:0] load_data,
  input wire logic       write_busy,
  input wire logic       fetch_no_read_while_write_section_only
);
  logic [15:0] busy_cnt_q;
  logic [2:0]  since_store_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Busy length is counted without reset, since a write outlives a reset.
  always_ff @(posedge clk_sys) begin
    busy_cnt_q <= write_busy ? busy_cnt_q + 16'h1 : 16'h0;
  end

  // Age of the last store, saturating so old stores never look recent.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) since_store_q <= 3'h7;
    else if (store_req) since_store_q <= 3'h0;
    else if (since_store_q != 3'h7) since_store_q <= since_store_q + 3'h1;
  end

  sequence armed_load_s;
    load_req && (ctrl_rdata[LOCK_FUSE_BIT] || ctrl_rdata[SIG_READ_BIT]);
  endsequence
  sequence disarmed_s;
    !ctrl_rdata[LOCK_FUSE_BIT] && !ctrl_rdata[SIG_READ_BIT];
  endsequence

  a_fetch_tracks_busy: assert property (fetch_no_read_while_write_section_only == write_busy)
    else $error("fetch restriction differs from write busy");
  a_lock_arm_ends: assert property ($rose(ctrl_rdata[LOCK_FUSE_BIT])
    |-> ##[1:6] !ctrl_rdata[LOCK_FUSE_BIT])
    else $error("lock read mode outlived its window");
  a_sig_arm_ends: assert property ($rose(ctrl_rdata[SIG_READ_BIT])
    |-> ##[1:5] !ctrl_rdata[SIG_READ_BIT])
    else $error("signature mode outlived its window");
  a_read_disarms: assert property (armed_load_s |-> ##[1:2] disarmed_s)
    else $error("read mode stayed armed after a load");
  a_busy_from_store: assert property ($rose(write_busy)
    |-> since_store_q <= 3'h3)
    else $error("write started without a store");
  a_write_length: assert property ($fell(write_busy)
    |-> busy_cnt_q >= WRITE_CYCLES - 1 && busy_cnt_q <= WRITE_CYCLES + 1)
    else $error("write busy length wrong");
  a_data_stands: assert property (!$past(load_req) && !$past(sys_rst)
    |-> $stable(load_data))
    else $error("load data changed without a load");
  a_reset_idle: assert property ($fell(sys_rst)
    |-> load_data == 8'h00 && ctrl_rdata[5:1] == 5'h00)
    else $error("state survived reset");
endmodule

/* File: test/fuse_lock_signature_readback_tb.sv */
// Self-checking bench for the core end and the read-back block.
`timescale 1ns/1ps
module fuse_lock_signature_readback_tb;
  import nvm_readback_pkg::*;
  localparam int WRITE_CYC = 20;
  logic        clk_sys, sys_rst, u_wr, u_load, u_store, u_pset, ee_busy;
  logic        res_valid, u_busy, op_start;
  logic [7:0]  u_data, result, c;
  logic [7:0]  nv [9]; // Fuse lo, lock, ext, hi, sig1, cal, sig2, mem, sig3.
  logic [15:0] u_ptr, p;
  logic [31:0] seed;
  int          n_errors, n_checks, i, j, k, gap;
  logic [15:0] sig_ptr [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004};

  nvm_readback_if link ();
  nvm_readback_core nvm_readback_core_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .bus(link.core), .user_ctrl_wr(u_wr),
    .user_ctrl_data(u_data), .user_load(u_load), .user_store(u_store),
    .user_ptr_set(u_pset), .user_ptr(u_ptr), .user_result(result),
    .user_result_valid(res_valid), .user_busy(u_busy));
  nvm_readback_device #(.WRITE_CYCLES(WRITE_CYC)) nvm_readback_device_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .bus(link.device),
    .lock_programmed(nv[1]), .fuse_low_programmed(nv[0]),
    .fuse_high_programmed(nv[3]), .fuse_ext_programmed(nv[2]),
    .sig_byte1(nv[4]), .sig_byte2(nv[6]), .sig_byte3(nv[8]),
    .osc_cal_byte(nv[5]), .program_mem_data(nv[7]),
    .eeprom_write_busy_flag(ee_busy), .nvm_op_start(op_start));
  nvm_readback_sva #(.WRITE_CYCLES(WRITE_CYC)) chk (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .load_req(link.load_req), .store_req(link.store_req),
    .ctrl_rdata(link.ctrl_rdata), .load_data(link.load_data),
    .write_busy(link.write_busy), .fetch_no_read_while_write_section_only(link.fetch_no_read_while_write_section_only));

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Refused or disarmed loads fall back to plain program memory.
  function automatic logic [7:0] expect_load(input logic [7:0] m,
      input logic [15:0] a, input int g);
    if (g > 2 || ee_busy) return nv[7];
    if (m == 8'h09) return (a < 16'h4) ? ~nv[a[1:0]] : 8'hff;
    if (m == 8'h21) return (a == 16'h4) ? nv[8] : nv[int'(a[1:0]) + 4];
    return nv[7];
  endfunction

  task automatic chk_byte(input string nm, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, g);
    chk_byte(nm, {7'h0, e}, {7'h0, g});
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Requests are raised at a falling edge and stand until the next pulse
  // or quiet, so back-to-back requests never touch a strobe twice a step.
  task automatic pulse(input logic w, l, s, input logic [7:0] d,
      input logic [15:0] a);
    {u_wr, u_load, u_store, u_pset, u_data, u_ptr} = {w, l, s, 1'b1, d, a};
    tick(1);
  endtask
  task automatic quiet();
    {u_wr, u_load, u_store, u_pset} = 4'h0;
  endtask
  task automatic load_get(input logic [15:0] a);
    pulse(0, 1, 0, 8'h00, a);
    quiet();
    k = 0;
    while (res_valid !== 1'b1 && k < 8) begin
      tick(1);
      k++;
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----
  // Clock, watchdog and main sequence
  // ----
  initial begin
    clk_sys = 0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    conclude();
  end
  initial begin
    {u_wr, u_load, u_store, u_pset, u_data, u_ptr, ee_busy} = '0;
    seed = 32'h2435745a;
    foreach (nv[j]) nv[j] = 8'h00;
    sys_rst = 1;
    tick(8);
    sys_rst = 0;
    // Random reads, armed or not, each followed by a load with no arming.
    for (i = 0; i < 30; i++) begin
      for (j = 0; j < 9; j++) begin
        seed = lfsr(seed);
        nv[j] = seed[7:0];
      end
      c = (seed[9:8] == 2'h0) ? 8'h00 : (seed[8] ? 8'h09 : 8'h21);
      p = (c == 8'h09) ? {14'h0, seed[11:10]} : sig_ptr[seed[11:10]];
      gap = (i < 8) ? i % 4 : int'(seed[13:12]);
      ee_busy = (i == 5);
      pulse(1, 0, 0, c, p);
      if (gap > 0) begin
        quiet();
        tick(gap);
      end
      load_get(p);
      chk_byte("armed load", expect_load(c, p, gap), result);
      load_get(p);
      chk_byte("plain load", nv[7], result);
    end
    // A store one cycle too late must not start a write.
    pulse(1, 0, 0, 8'h09, 16'h0001);
    quiet();
    tick(4);
    pulse(0, 0, 1, 8'h00, 16'h0001);
    quiet();
    tick(1);
    chk_bit("late op start", 1'b0, op_start);
    tick(2);
    chk_bit("late write_busy", 1'b0, link.write_busy);
    // A timely store writes the lock bits; a reset must not cut it short.
    pulse(1, 0, 0, 8'h09, 16'h0001);
    pulse(0, 0, 1, 8'h00, 16'h0001);
    quiet();
    tick(1);
    chk_bit("op start", 1'b1, op_start);
    tick(2);
    chk_bit("write_busy", 1'b1, link.write_busy);
    chk_bit("fetch_no_read_while_write_section_only", 1'b1, link.fetch_no_read_while_write_section_only);
    chk_bit("user busy", 1'b1, u_busy);
    chk_bit("ctrl busy bit", 1'b1, link.ctrl_rdata[0]);
    sys_rst = 1;
    tick(2);
    sys_rst = 0;
    tick(1);
    chk_bit("busy after reset", 1'b1, link.write_busy);
    k = 0;
    while (link.write_busy === 1'b1 && k < 40) begin
      tick(1);
      k++;
    end
    chk_bit("write done", 1'b0, link.write_busy);
    load_get(16'h0001);
    chk_byte("load after write", nv[7], result);
    conclude();
  end
endmodule
